/* File: logic/core_ops.v */
// Core executing branch, call, clear, watchdog, complement and compare ops.
// Summary of operation
// - branch_on_zero_flag jumps to PC+2+2n only when zero flag set.
// - Call takes 20-bit target and shadow bit; target loads PC<20:1>.
// - Call pushes PC+4 onto the return stack top unless the stack is full (pointer 1Fh).
// - Call with shadow bit set copies W, status, bank select to shadows.
// - Clear-file writes zero to the register and sets only zero flag.
// - Bank bit zero selects access bank; one selects bank select register.
// - Extended set with bank bit zero indexes addresses up to 5Fh.
// - Watchdog clear zeroes count and postscaler, sets timeout and powerdown.
// - Complement inverts file, writes W or file, updates N and Z only.
// - Compare-equal skips next instruction on equality, flags untouched.
// - Compare-greater skips when file exceeds W, unsigned.
// - Compare-less skips when file below W, unsigned, flags untouched.
// - Skips take one, two, or three cycles for two-word skipped op.
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`include "core_ops_regs.vh"
module core_ops (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest
);

	reg  [15:0] pmem [0:255];
	reg  [7:0]  dmem [0:4095];
	reg  [20:0] stack [0:31];

	reg         run_r;
	reg         ext_en_r;
	reg  [7:0]  prog_addr_r;
	reg  [11:0] dmem_addr_r;
	reg  [20:0] pc_r;
	reg  [7:0]  working_register_r;
	reg  [7:0]  status_r;
	reg  [3:0]  bank_select_register_r;
	reg  [11:0] fsr2_r;
	reg  [7:0]  work_shadow_r;
	reg  [7:0]  flags_shadow_r;
	reg  [3:0]  bank_select_shadow_r;
	reg  [4:0]  sp_r;
	reg  [7:0]  watchdog_counter_r;
	reg  [3:0]  wdt_post_r;
	reg         timeout_status_bit_r;
	reg         powerdown_status_bit_r;
	reg  [15:0] cycles_r;
	reg  [15:0] ir_r;
	reg  [15:0] ir2_r;
	reg  [7:0]  fval_r;
	reg  [7:0]  comp_r;
	reg  [1:0]  nop_cnt_r;
	reg         ack_r;
	reg  [31:0] readdata_r;
	reg  [31:0] rd_nxt;

	wire [1:0]  phase;
	wire [11:0] faddr;
	wire [20:0] return_stack_top;
	wire        bus_wr;
	wire        bus_rd;
	wire [3:0]  reg_idx;
	wire        is_bz;
	wire        is_call;
	wire        is_clear_file_op;
	wire        is_watchdog_clear_op;
	wire        is_complement_file_op;
	wire        is_cpeq;
	wire        is_cpgt;
	wire        is_cplt;
	wire        skip_take;
	wire        next_two_word;
	wire [20:0] bz_target;
	wire        cpu_dwe;
	wire        bus_dwe;
	wire [31:0] wmerge;

	quarter_phase u_phase (
		.sys_clk (sys_clk),
		.rst     (rst),
		.run     (run_r),
		.phase_r (phase)
	);

	file_addr_resolve u_resolve (
		.f      (ir_r[7:0]),
		.a      (ir_r[8]),
		.ext_en (ext_en_r),
		.bank_select_register    (bank_select_register_r),
		.fsr2   (fsr2_r),
		.addr   (faddr)
	);

	// Byte lanes that the master does not enable keep their old contents.
	function [31:0] merge;
		input [31:0] old;
		input [31:0] din;
		input [3:0]  be;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				merge[i*8 +: 8] = be[i] ? din[i*8 +: 8] : old[i*8 +: 8];
			end
		end
	endfunction

	assign reg_idx = avs_address[5:2];
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign bus_wr = avs_write & ack_r;
	assign bus_rd = avs_read & ~ack_r;
	assign avs_readdata = readdata_r;
	assign wmerge = merge(rd_nxt, avs_writedata, avs_byteenable);
	// An empty stack reads as zero; the stack array itself carries no reset.
	assign return_stack_top = (sp_r == `SP_RST) ? 21'h000000 : stack[sp_r];

	assign is_bz     = (ir_r[15:8] == `OP_BZ);
	assign is_call   = (ir_r[15:9] == `OP_CALL);
	assign is_clear_file_op   = (ir_r[15:9] == `OP_CLEAR_FILE_OP);
	assign is_watchdog_clear_op = (ir_r == `OP_WATCHDOG_CLEAR_OP);
	assign is_complement_file_op   = (ir_r[15:10] == `OP_COMPLEMENT_FILE_OP);
	assign is_cpeq   = (ir_r[15:9] == `OP_COMPARE_SKIP_EQUAL_OP);
	assign is_cpgt   = (ir_r[15:9] == `OP_COMPARE_SKIP_GREATER_OP);
	assign is_cplt   = (ir_r[15:9] == `OP_COMPARE_SKIP_LESS_OP);

	// Unsigned compares; none of them touches the status flags.
	assign skip_take = (is_cpeq & (fval_r == working_register_r)) |
		(is_cpgt & (fval_r > working_register_r)) |
		(is_cplt & (fval_r < working_register_r));

	assign next_two_word = (ir2_r[15:9] == `OP_CALL) |
		(ir2_r[15:8] == `OP_GOTO) | (ir2_r[15:8] == `OP_LFSR) |
		(ir2_r[15:12] == `OP_MOVFF);

	assign bz_target = pc_r + 21'h000002 +
		{{12{ir_r[7]}}, ir_r[7:0], 1'b0};

	assign cpu_dwe = run_r && phase == 2'h3 && nop_cnt_r == 2'h0 &&
		(is_clear_file_op || (is_complement_file_op && ir_r[9]));
	assign bus_dwe = bus_wr && !run_r && reg_idx == `REG_DMEM_DATA &&
		avs_byteenable[0];

	// Memories carry no reset; the bus loads program and data memory while the core is halted.
	always @(posedge sys_clk) begin
		if (cpu_dwe) begin
			dmem[faddr] <= is_clear_file_op ? 8'h00 : comp_r;
		end else if (bus_dwe) begin
			dmem[dmem_addr_r] <= avs_writedata[7:0];
		end
		if (bus_wr && !run_r && reg_idx == `REG_PROG_DATA) begin
			pmem[prog_addr_r] <= avs_writedata[15:0];
		end
		if (run_r && phase == 2'h3 && nop_cnt_r == 2'h0 && is_call &&
			sp_r != `SP_MAX) begin
			stack[sp_r + 5'h01] <= pc_r + 21'h000004;
		end
	end

	always @* begin
		case (reg_idx)
		`REG_CTRL:      rd_nxt = {30'h0, ext_en_r, run_r};
		`REG_PROG_ADDR: rd_nxt = {24'h0, prog_addr_r};
		`REG_PROG_DATA: rd_nxt = {16'h0, pmem[prog_addr_r]};
		`REG_PC:        rd_nxt = {11'h0, pc_r};
		`REG_WORKING_REGISTER:      rd_nxt = {24'h0, working_register_r};
		`REG_STATUS:    rd_nxt = {24'h0, status_r};
		`REG_BSR:       rd_nxt = {28'h0, bank_select_register_r};
		`REG_FSR2:      rd_nxt = {20'h0, fsr2_r};
		`REG_SHADOW:    rd_nxt = {12'h0, bank_select_shadow_r,
			flags_shadow_r, work_shadow_r};
		`REG_TOS:       rd_nxt = {6'h0, sp_r, return_stack_top};
		`REG_WDT:       rd_nxt = {14'h0, powerdown_status_bit_r,
			timeout_status_bit_r, 4'h0, wdt_post_r, watchdog_counter_r};
		`REG_DMEM_ADDR: rd_nxt = {20'h0, dmem_addr_r};
		`REG_DMEM_DATA: rd_nxt = {24'h0, dmem[dmem_addr_r]};
		`REG_CYCLES:    rd_nxt = {16'h0, cycles_r};
		default:        rd_nxt = 32'h0;
		endcase
	end

	// Every access waits exactly one cycle so read data come from a flop.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
			readdata_r <= 32'h0;
		end else begin
			ack_r <= (avs_read | avs_write) & ~ack_r;
			if (bus_rd) begin
				readdata_r <= rd_nxt;
			end
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			run_r <= 1'b0;
			ext_en_r <= 1'b0;
			prog_addr_r <= 8'h00;
			dmem_addr_r <= 12'h000;
			pc_r <= `PC_RST;
			working_register_r <= `WORKING_REGISTER_RST;
			status_r <= `STATUS_RST;
			bank_select_register_r <= `BSR_RST;
			fsr2_r <= `FSR2_RST;
			work_shadow_r <= `WORKING_REGISTER_RST;
			flags_shadow_r <= `STATUS_RST;
			bank_select_shadow_r <= `BSR_RST;
			sp_r <= `SP_RST;
			watchdog_counter_r <= 8'h00;
			wdt_post_r <= 4'h0;
			timeout_status_bit_r <= 1'b1;
			powerdown_status_bit_r <= 1'b1;
			cycles_r <= 16'h0000;
			ir_r <= `OP_NOP;
			ir2_r <= `OP_NOP;
			fval_r <= 8'h00;
			comp_r <= 8'h00;
			nop_cnt_r <= 2'h0;
		end else begin
			if (bus_wr) begin
				// The control word stays writable so a running core can halt.
				if (reg_idx == `REG_CTRL) begin
					run_r <= wmerge[`CTRL_RUN_BIT];
					ext_en_r <= wmerge[`CTRL_EXT_BIT];
				end
				if (reg_idx == `REG_PROG_ADDR) begin
					prog_addr_r <= wmerge[7:0];
				end
				if (reg_idx == `REG_PROG_DATA) begin
					prog_addr_r <= prog_addr_r + 8'h01;
				end
				if (reg_idx == `REG_DMEM_ADDR) begin
					dmem_addr_r <= wmerge[11:0];
				end
				// State registers only take bus writes while halted.
				if (!run_r) begin
					case (reg_idx)
					`REG_PC:     pc_r <= {wmerge[20:1], 1'b0};
					`REG_WORKING_REGISTER:   working_register_r <= wmerge[7:0];
					`REG_STATUS: status_r <= wmerge[7:0];
					`REG_BSR:    bank_select_register_r <= wmerge[3:0];
					`REG_FSR2:   fsr2_r <= wmerge[11:0];
					default:     cycles_r <= cycles_r;
					endcase
				end
			end
			if (run_r) begin
				case (phase)
				2'h0: begin
					if (nop_cnt_r != 2'h0) begin
						ir_r <= `OP_NOP;
					end else begin
						ir_r <= pmem[pc_r[8:1]];
						ir2_r <= pmem[pc_r[8:1] + 8'h01];
					end
				end
				2'h1: begin
					fval_r <= dmem[faddr];
				end
				2'h2: begin
					comp_r <= ~fval_r;
				end
				default: begin
					cycles_r <= cycles_r + 16'h0001;
					watchdog_counter_r <= watchdog_counter_r + 8'h01;
					if (watchdog_counter_r == 8'hFF) begin
						wdt_post_r <= wdt_post_r + 4'h1;
						if (wdt_post_r == 4'hF) begin
							timeout_status_bit_r <= 1'b0;
						end
					end
					if (nop_cnt_r != 2'h0) begin
						nop_cnt_r <= nop_cnt_r - 2'h1;
					end else begin
						pc_r <= pc_r + 21'h000002;
						if (is_bz && status_r[`ST_Z_BIT]) begin
							pc_r <= bz_target;
							nop_cnt_r <= 2'h1;
						end
						if (is_call || ir_r[15:8] == `OP_GOTO) begin
							pc_r <= {ir2_r[11:0], ir_r[7:0], 1'b0};
							nop_cnt_r <= 2'h1;
						end
						if (is_call) begin
							if (sp_r != `SP_MAX) begin
								sp_r <= sp_r + 5'h01;
							end
							if (ir_r[8]) begin
								work_shadow_r <= working_register_r;
								flags_shadow_r <= status_r;
								bank_select_shadow_r <= bank_select_register_r;
							end
						end
						if (is_clear_file_op) begin
							status_r[`ST_Z_BIT] <= 1'b1;
						end
						if (is_complement_file_op) begin
							status_r[`ST_N_BIT] <= comp_r[7];
							status_r[`ST_Z_BIT] <= (comp_r == 8'h00);
							if (!ir_r[9]) begin
								working_register_r <= comp_r;
							end
						end
						if (is_watchdog_clear_op) begin
							watchdog_counter_r <= 8'h00;
							wdt_post_r <= 4'h0;
							timeout_status_bit_r <= 1'b1;
							powerdown_status_bit_r <= 1'b1;
						end
						// A two-word victim needs a second nop cycle.
						if (skip_take) begin
							nop_cnt_r <= next_two_word ? 2'h2 : 2'h1;
							pc_r <= next_two_word ? pc_r + 21'h000006 :
								pc_r + 21'h000004;
						end
					end
				end
				endcase
			end
		end
	end

endmodule

/* File: logic/core_ops_regs.vh */
// Register offsets, field positions, reset values and opcodes of the core.
`ifndef CORE_OPS_REGS_VH
`define CORE_OPS_REGS_VH

`define REG_CTRL       4'h0
`define REG_PROG_ADDR  4'h1
`define REG_PROG_DATA  4'h2
`define REG_PC         4'h3
`define REG_WORKING_REGISTER       4'h4
`define REG_STATUS     4'h5
`define REG_BSR        4'h6
`define REG_FSR2       4'h7
`define REG_SHADOW     4'h8
`define REG_TOS        4'h9
`define REG_WDT        4'hA
`define REG_DMEM_ADDR  4'hB
`define REG_DMEM_DATA  4'hC
`define REG_CYCLES     4'hD

`define CTRL_RUN_BIT   0
`define CTRL_EXT_BIT   1

`define ST_C_BIT       0
`define ST_Z_BIT       2
`define ST_N_BIT       4

`define WDT_TO_BIT     16
`define WDT_PD_BIT     17

`define PC_RST         21'h000000
`define WORKING_REGISTER_RST       8'h00
`define STATUS_RST     8'h00
`define BSR_RST        4'h0
`define FSR2_RST       12'h000
`define SP_RST         5'h00
`define SP_MAX         5'h1F

`define OP_NOP         16'h0000
`define OP_BZ          8'hE0
`define OP_CALL        7'h76
`define OP_GOTO        8'hEF
`define OP_LFSR        8'hEE
`define OP_MOVFF       4'hC
`define OP_CLEAR_FILE_OP        7'h35
`define OP_WATCHDOG_CLEAR_OP      16'h0004
`define OP_COMPLEMENT_FILE_OP        6'h07
`define OP_COMPARE_SKIP_EQUAL_OP      7'h31
`define OP_COMPARE_SKIP_GREATER_OP      7'h32
`define OP_COMPARE_SKIP_LESS_OP      7'h30

`define ACCESS_SPLIT   8'h60
`define ILO_LIMIT      8'h5F

`endif

/* File: logic/quarter_phase.v */
// Quarter-phase sequencer that splits each instruction cycle into four.
module quarter_phase (
	input  wire       sys_clk,
	input  wire       rst,
	input  wire       run,
	output reg  [1:0] phase_r
);

	// Halting returns to the decode quarter so a restart is always aligned.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			phase_r <= 2'h0;
		end else if (!run) begin
			phase_r <= 2'h0;
		end else begin
			phase_r <= phase_r + 2'h1;
		end
	end

endmodule

/* File: logic/file_addr_resolve.v */
// Resolves an 8-bit file operand into a 12-bit data memory address.
`include "core_ops_regs.vh"
module file_addr_resolve (
	input  wire [7:0]  f,
	input  wire        a,
	input  wire        ext_en,
	input  wire [3:0]  bank_select_register,
	input  wire [11:0] fsr2,
	output reg  [11:0] addr
);

	always @* begin
		if (a) begin
			addr = {bank_select_register, f};
		end else if (ext_en && f <= `ILO_LIMIT) begin
			addr = fsr2 + {4'h0, f};
		end else if (f < `ACCESS_SPLIT) begin
			addr = {4'h0, f};
		end else begin
			addr = {4'hF, f};
		end
	end

endmodule

/* File: testbench/core_ops_chk_sva.sv */
// Bus timing and register format checks bound to the core top.
`include "core_ops_regs.vh"
module core_ops_chk (
	input wire        sys_clk,
	input wire        rst,
	input wire [5:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0]  avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest
);
	timeunit 1ns;
	timeprecision 1ns;
	wire       req = avs_read | avs_write;
	wire       rd_ok = avs_read & ~avs_waitrequest;
	wire [3:0] idx = avs_address[5:2];
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
		else $error("wait missing at request start");
	a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait longer than one cycle");
	a_wait_idle: assert property (!req |-> !avs_waitrequest)
		else $error("wait raised without request");
	a_rd_hold: assert property (!(avs_read && avs_waitrequest) |=>
		$stable(avs_readdata)) else $error("read data moved");
	a_rd_unmapped: assert property (rd_ok && idx >= 4'hE |-> avs_readdata == 0)
		else $error("unmapped read not zero");
	a_pc_even: assert property (rd_ok && idx == `REG_PC |->
		avs_readdata[0] == 1'h0 && avs_readdata[31:21] == 11'h0)
		else $error("program counter odd or too wide");
	a_tos_even: assert property (rd_ok && idx == `REG_TOS |->
		avs_readdata[0] == 1'h0 && avs_readdata[31:26] == 6'h0)
		else $error("stack top format wrong");
	a_wdt_fmt: assert property (rd_ok && idx == `REG_WDT |->
		avs_readdata[31:18] == 14'h0 && avs_readdata[15:12] == 4'h0)
		else $error("watchdog format wrong");
	a_shadow_fmt: assert property (rd_ok && idx == `REG_SHADOW |->
		avs_readdata[31:20] == 12'h0) else $error("shadow format wrong");
	c_write: cover property (avs_write && !avs_waitrequest);
	c_unmapped: cover property (rd_ok && idx >= 4'hE);
	c_tos: cover property (rd_ok && idx == `REG_TOS);
endmodule
bind core_ops core_ops_chk chk_u (
	.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
);

/* File: testbench/cpu_branch_call_clear_compare_ops_tb.sv */
// Self-checking bench that runs small programs through the register bus.
`include "core_ops_regs.vh"
module cpu_branch_call_clear_compare_ops_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk = 1'h0;
	logic        rst = 1'h1;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	int          failures = 0;
	int          checks = 0;
	logic [31:0] q;
	core_ops dut_u (
		.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
	);
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end
	task close_out;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cmp(input [31:0] got, input [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Waitrequest and read data are taken at the rising edge itself, before
	// the updates of that edge land, and the request is released right then.
	task bus(input w, input [3:0] r, input [31:0] d);
		int n;
		@(posedge sys_clk);
		avs_address <= {r, 2'h0};
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 50);
		if (n >= 50)
			failures++;
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask
	task chk(input [3:0] r, input [31:0] e);
		bus(1'h0, r, 32'h0);
		cmp(q, e);
	endtask
	task ld(input [7:0] a, input [15:0] w);
		bus(1'h1, `REG_PROG_ADDR, {24'h0, a});
		bus(1'h1, `REG_PROG_DATA, {16'h0, w});
	endtask
	task mem_wr(input [11:0] a, input [7:0] d);
		bus(1'h1, `REG_DMEM_ADDR, {20'h0, a});
		bus(1'h1, `REG_DMEM_DATA, {24'h0, d});
	endtask
	task mem_chk(input [11:0] a, input [7:0] e);
		bus(1'h1, `REG_DMEM_ADDR, {20'h0, a});
		chk(`REG_DMEM_DATA, {24'h0, e});
	endtask
	// Every program ends in a jump to itself, so the final counter does not
	// depend on when the halt lands.
	task go(input [31:0] pc, input [1:0] ctrl, input [31:0] stop);
		int n;
		bus(1'h1, `REG_PC, pc);
		bus(1'h1, `REG_CTRL, {30'h0, ctrl});
		n = 0;
		do begin
			bus(1'h0, `REG_PC, 32'h0);
			n++;
		end while (q !== stop && n < 40);
		repeat (8) bus(1'h0, `REG_CYCLES, 32'h0);
		bus(1'h1, `REG_CTRL, {30'h0, ctrl[1], 1'h0});
		chk(`REG_PC, stop);
	endtask
	task s_reset;
		chk(`REG_PC, 32'h0);
		chk(`REG_TOS, 32'h0);
		chk(`REG_WDT, 32'h00030000);
		bus(1'h1, 4'hE, 32'hFFFFFFFF);
		chk(4'hE, 32'h0);
		bus(1'h1, `REG_SHADOW, 32'hFFFFFFFF);
		chk(`REG_SHADOW, 32'h0);
	endtask
	// Two runs without a clear leave a count that one cleared run stays below.
	task s_wdt;
		logic [7:0] c1;
		ld(8'h00, 16'hEF00);
		ld(8'h01, 16'hF000);
		go(32'h0, 2'h1, 32'h0);
		go(32'h0, 2'h1, 32'h0);
		bus(1'h0, `REG_WDT, 32'h0);
		c1 = q[7:0];
		cmp({31'h0, c1 > 8'h04}, 32'h1);
		ld(8'h00, `OP_WATCHDOG_CLEAR_OP);
		ld(8'h01, 16'hEF01);
		ld(8'h02, 16'hF000);
		go(32'h0, 2'h1, 32'h2);
		bus(1'h0, `REG_WDT, 32'h0);
		cmp({q[31:8], 7'h0, q[7:0] < c1}, 32'h00030001);
	endtask
	task s_bz;
		ld(8'h00, 16'hE003);
		ld(8'h01, 16'hEF01);
		ld(8'h02, 16'hF000);
		ld(8'h04, 16'hEF04);
		ld(8'h05, 16'hF000);
		bus(1'h1, `REG_STATUS, 32'h04);
		go(32'h0, 2'h1, 32'h8);
		chk(`REG_STATUS, 32'h04);
		bus(1'h1, `REG_STATUS, 32'h0);
		go(32'h0, 2'h1, 32'h2);
	endtask
	task s_call;
		ld(8'h00, 16'hED08);
		ld(8'h01, 16'hF000);
		ld(8'h08, 16'hEF08);
		ld(8'h09, 16'hF000);
		ld(8'h0A, 16'hEC08);
		ld(8'h0B, 16'hF000);
		bus(1'h1, `REG_WORKING_REGISTER, 32'h5A);
		bus(1'h1, `REG_STATUS, 32'h15);
		bus(1'h1, `REG_BSR, 32'h3);
		go(32'h0, 2'h1, 32'h10);
		chk(`REG_TOS, 32'h00200004);
		chk(`REG_SHADOW, 32'h0003155A);
		bus(1'h1, `REG_WORKING_REGISTER, 32'h11);
		go(32'h14, 2'h1, 32'h10);
		chk(`REG_TOS, 32'h00400018);
		chk(`REG_SHADOW, 32'h0003155A);
	endtask
	task s_clear_file_op;
		mem_wr(12'h234, 8'hA5);
		mem_wr(12'hF70, 8'h77);
		mem_wr(12'h270, 8'h66);
		bus(1'h1, `REG_BSR, 32'h2);
		bus(1'h1, `REG_STATUS, 32'h11);
		ld(8'h00, 16'h6B34);
		ld(8'h01, 16'h6A70);
		ld(8'h02, 16'hEF02);
		ld(8'h03, 16'hF000);
		go(32'h0, 2'h1, 32'h4);
		mem_chk(12'h234, 8'h00);
		mem_chk(12'hF70, 8'h00);
		mem_chk(12'h270, 8'h66);
		chk(`REG_STATUS, 32'h15);
	endtask
	task s_complement_file_op;
		mem_wr(12'h020, 8'h13);
		mem_wr(12'h320, 8'hFF);
		bus(1'h1, `REG_FSR2, 32'h300);
		bus(1'h1, `REG_STATUS, 32'h01);
		ld(8'h00, 16'h1C20);
		ld(8'h01, 16'hEF01);
		ld(8'h02, 16'hF000);
		go(32'h0, 2'h1, 32'h2);
		chk(`REG_WORKING_REGISTER, 32'hEC);
		chk(`REG_STATUS, 32'h11);
		ld(8'h00, 16'h1E20);
		go(32'h0, 2'h3, 32'h2);
		mem_chk(12'h320, 8'h00);
		mem_chk(12'h020, 8'h13);
		chk(`REG_STATUS, 32'h05);
	endtask
	task s_cmp;
		int i;
		logic [7:0] f;
		logic sk;
		bus(1'h1, `REG_WORKING_REGISTER, 32'h7F);
		bus(1'h1, `REG_STATUS, 32'h15);
		ld(8'h01, 16'hEF01);
		ld(8'h02, 16'hF000);
		ld(8'h03, 16'hEF03);
		ld(8'h04, 16'hF000);
		for (i = 0; i < 9; i++) begin
			f = 8'h7E + 8'(i % 3);
			sk = i < 3 ? f == 8'h7F : i < 6 ? f > 8'h7F : f < 8'h7F;
			mem_wr(12'h040, f);
			if (i < 3)
				ld(8'h00, {`OP_COMPARE_SKIP_EQUAL_OP, 9'h040});
			else if (i < 6)
				ld(8'h00, {`OP_COMPARE_SKIP_GREATER_OP, 9'h040});
			else
				ld(8'h00, {`OP_COMPARE_SKIP_LESS_OP, 9'h040});
			go(32'h0, 2'h1, sk ? 32'h6 : 32'h2);
			chk(`REG_STATUS, 32'h15);
		end
	endtask
	initial begin
		#2400000;
		failures++;
		close_out;
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'h0;
		s_reset;
		s_wdt;
		s_bz;
		s_call;
		s_clear_file_op;
		s_complement_file_op;
		s_cmp;
		close_out;
	end
endmodule
